// >>> design/mapc_codec.sv
// Encoder of rate packets and decoder of aiding packet payloads
`include "mapc_defs.svh"

// Notes on behaviour
// R1 - Angular velocity packet: id 42, 12 bytes
// R2 - Rate X, Y, Z fp32 at 0, 4, 8
// R3 - Angular acceleration packet: id 43, 12 bytes
// R4 - Acceleration X, Y, Z fp32 at 0, 4, 8
// R5 - Position-velocity packet: id 44, 60 bytes
// R6 - fp64 lat lon height, fp32 NED velocity
// R7 - Deviations fp32 at offsets 36 to 56
// R8 - Position packet: id 45, 36 bytes
// R9 - fp64 position, fp32 deviations at 24-32
// R10 - Velocity packet: id 46, 24 bytes
// R11 - fp32 velocity 0-8, deviations 12-20
// R12 - Wrong length aiding packets dropped, error flagged
// R13 - IEEE floats, least significant byte first
module mapc_codec (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                tx_av_req,
	input  wire logic                tx_aa_req,
	input  wire mapc_pkg::mapc_vec3_s tx_av,
	input  wire mapc_pkg::mapc_vec3_s tx_aa,
	output logic                     tx_busy,
	output mapc_pkg::mapc_hdr_s      tx_hdr,
	output logic                     tx_valid,
	output logic [7:0]               tx_data,
	output logic                     tx_last,
	input  wire logic                tx_ready,
	input  wire mapc_pkg::mapc_hdr_s rx_hdr,
	input  wire logic                rx_start,
	input  wire logic                rx_valid,
	input  wire logic [7:0]          rx_data,
	input  wire logic                rx_end,
	output mapc_pkg::mapc_pos_s      rx_pos,
	output mapc_pkg::mapc_vel_s      rx_vel,
	output logic                     rx_pos_upd,
	output logic                     rx_vel_upd,
	output logic                     rx_len_err
);
	import mapc_pkg::*;

	// ----------------------------------------------------------
	// Transmit side
	// ----------------------------------------------------------
	mapc_tx_e   tx_st_r;
	mapc_tx_e   tx_st_nxt;
	mapc_vec3_s tx_buf_r;
	mapc_hdr_s  tx_hdr_r;
	logic [7:0] tx_idx_r;
	logic [7:0] tx_data_r;
	logic       tx_valid_r;
	logic       tx_last_r;
	logic       tx_start;
	logic       tx_step;
	logic       tx_done;
	logic [2:0] tx_hit;
	logic [7:0] tx_lane [3];
	logic [7:0] tx_byte;
	logic [7:0] tx_nidx;

	// Payload offsets of the three axes
	localparam logic [7:0] AX_OFS [3] =
		'{`MAPC_OFS_X, `MAPC_OFS_Y, `MAPC_OFS_Z};  // [R2] [R4]

	assign tx_start = (tx_st_r == MAPC_TX_IDLE) && (tx_av_req || tx_aa_req);
	assign tx_step  = tx_valid_r && tx_ready;
	assign tx_done  = tx_step && tx_last_r;
	assign tx_nidx  = tx_start ? 8'h00 : tx_idx_r + 8'h01;

	// Byte lanes of the held vector
	for (genvar g = 0; g < 3; g++) begin : g_tx_ax
		mapc_field_sel #(.W(4)) u_sel (
			.base  (AX_OFS[g]),
			.idx   (tx_nidx),
			.field (tx_buf_r[(2-g)*32 +: 32]),
			.hit   (tx_hit[g]),
			.lane  (tx_lane[g])
		);
	end

	// Lanes for the first byte come from the request itself
	logic [95:0] tx_src;
	assign tx_src  = tx_start ? (tx_av_req ? tx_av : tx_aa) : tx_buf_r;
	assign tx_byte = tx_start ? tx_src[95-24 -: 8] :
		(tx_lane[0] | tx_lane[1] | tx_lane[2]);  // [R13]

	// ----------------------------------------------------------
	// Transmit sequencing
	// ----------------------------------------------------------
	always_comb begin
		tx_st_nxt = tx_st_r;
		case (tx_st_r)
			MAPC_TX_IDLE: begin
				if (tx_start) begin
					tx_st_nxt = MAPC_TX_SEND;
				end
			end
			MAPC_TX_SEND: begin
				if (tx_done) begin
					tx_st_nxt = MAPC_TX_IDLE;
				end
			end
			default: tx_st_nxt = MAPC_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_r <= MAPC_TX_IDLE;
		end else begin
			tx_st_r <= tx_st_nxt;
		end
	end

	// Angular velocity wins when both are asked in one cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_buf_r <= '0;
			tx_hdr_r <= '0;
		end else if (tx_start) begin
			tx_buf_r <= tx_src;
			tx_hdr_r.id  <= tx_av_req ? `MAPC_ID_ANG_VEL :
				`MAPC_ID_ANG_ACC;  // [R1] [R3]
			tx_hdr_r.len <= `MAPC_LEN_ANG;  // [R1] [R3]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_idx_r   <= 8'h00;
			tx_data_r  <= 8'h00;
			tx_valid_r <= 1'b0;
			tx_last_r  <= 1'b0;
		end else if (tx_start || (tx_step && !tx_last_r)) begin
			tx_idx_r   <= tx_nidx;
			tx_data_r  <= tx_byte;
			tx_valid_r <= 1'b1;
			tx_last_r  <= (tx_nidx == `MAPC_LEN_ANG - 8'h01);  // [R1] [R3]
		end else if (tx_done) begin
			tx_valid_r <= 1'b0;
			tx_last_r  <= 1'b0;
		end
	end

	// ----------------------------------------------------------
	// Transmit outputs
	// ----------------------------------------------------------

	assign tx_busy  = (tx_st_r != MAPC_TX_IDLE);
	assign tx_hdr   = tx_hdr_r;
	assign tx_valid = tx_valid_r;
	assign tx_data  = tx_data_r;
	assign tx_last  = tx_last_r;

	// ----------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------
	logic [7:0]   rx_id_r;
	logic         rx_ok_r;
	logic         rx_act_r;
	logic [7:0]   rx_cnt_r;
	logic [479:0] rx_sh_r;
	mapc_pos_s    rx_pos_r;
	mapc_vel_s    rx_vel_r;
	logic         rx_pos_upd_r;
	logic         rx_vel_upd_r;
	logic         rx_err_r;
	logic         rx_known;
	logic [7:0]   rx_need;
	logic         rx_fin;
	logic         rx_good;

	// Expected payload length per identifier
	logic         hdr_pv;
	logic         hdr_ps;
	logic         hdr_vs;
	assign hdr_pv  = (rx_hdr.id == `MAPC_ID_POS_VEL);  // [R5]
	assign hdr_ps  = (rx_hdr.id == `MAPC_ID_POS);      // [R8]
	assign hdr_vs  = (rx_hdr.id == `MAPC_ID_VEL);      // [R10]
	assign rx_need = hdr_pv ? `MAPC_LEN_POS_VEL :  // [R5]
		hdr_ps ? `MAPC_LEN_POS :                   // [R8]
		hdr_vs ? `MAPC_LEN_VEL :                   // [R10]
		8'h00;
	assign rx_known = (rx_need != 8'h00);
	assign rx_fin   = rx_act_r && rx_end;
	assign rx_good  = rx_fin && rx_ok_r && (rx_cnt_r == rx_hdr.len);  // [R12]

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_id_r  <= 8'h00;
			rx_ok_r  <= 1'b0;
			rx_act_r <= 1'b0;
			rx_cnt_r <= 8'h00;
		end else if (rx_start) begin
			rx_id_r  <= rx_hdr.id;
			rx_ok_r  <= rx_known && (rx_hdr.len == rx_need);  // [R12]
			rx_act_r <= rx_known;
			rx_cnt_r <= 8'h00;
		end else if (rx_fin) begin
			rx_act_r <= 1'b0;
		end else if (rx_act_r && rx_valid) begin
			rx_cnt_r <= rx_cnt_r + 8'h01;
		end
	end

	// ----------------------------------------------------------
	// Receive payload store
	// ----------------------------------------------------------
	// Bytes are written in place so that byte n lands at bits 8n upward
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sh_r <= '0;
		end else if (rx_act_r && rx_valid && !rx_end && rx_ok_r) begin
			rx_sh_r[rx_cnt_r[5:0]*8 +: 8] <= rx_data;  // [R13]
		end
	end

	// ----------------------------------------------------------
	// Receive field decode
	// ----------------------------------------------------------
	// Field extraction, little-endian at documented offsets
	function automatic mapc_fp32_t f32(input logic [479:0] s,
		input logic [7:0] o);
		f32 = s[o*8 +: 32];
	endfunction : f32
	function automatic mapc_fp64_t f64(input logic [479:0] s,
		input logic [7:0] o);
		f64 = s[o*8 +: 64];
	endfunction : f64

	// Which aiding record a good payload carries
	logic      is_pv;
	logic      is_ps;
	logic      is_vs;
	assign is_pv = rx_good && (rx_id_r == `MAPC_ID_POS_VEL);  // [R5]
	assign is_ps = rx_good && (rx_id_r == `MAPC_ID_POS);      // [R8]
	assign is_vs = rx_good && (rx_id_r == `MAPC_ID_VEL);      // [R10]

	// Combined packet fields
	mapc_pos_s pv_pos;
	mapc_vel_s pv_vel;
	assign pv_pos.lat    = f64(rx_sh_r, `MAPC_PV_OFS_LAT);   // [R6]
	assign pv_pos.lon    = f64(rx_sh_r, `MAPC_PV_OFS_LON);   // [R6]
	assign pv_pos.hgt    = f64(rx_sh_r, `MAPC_PV_OFS_HGT);   // [R6]
	assign pv_vel.vn     = f32(rx_sh_r, `MAPC_PV_OFS_VN);    // [R6]
	assign pv_vel.ve     = f32(rx_sh_r, `MAPC_PV_OFS_VE);    // [R6]
	assign pv_vel.vd     = f32(rx_sh_r, `MAPC_PV_OFS_VD);    // [R6]
	assign pv_pos.lat_sd = f32(rx_sh_r, `MAPC_PV_OFS_SLAT);  // [R7]
	assign pv_pos.lon_sd = f32(rx_sh_r, `MAPC_PV_OFS_SLON);  // [R7]
	assign pv_pos.hgt_sd = f32(rx_sh_r, `MAPC_PV_OFS_SHGT);  // [R7]
	assign pv_vel.vn_sd  = f32(rx_sh_r, `MAPC_PV_OFS_SVN);   // [R7]
	assign pv_vel.ve_sd  = f32(rx_sh_r, `MAPC_PV_OFS_SVE);   // [R7]
	assign pv_vel.vd_sd  = f32(rx_sh_r, `MAPC_PV_OFS_SVD);   // [R7]

	// Position packet fields
	mapc_pos_s ps_pos;
	assign ps_pos.lat    = f64(rx_sh_r, `MAPC_PV_OFS_LAT);   // [R9]
	assign ps_pos.lon    = f64(rx_sh_r, `MAPC_PV_OFS_LON);   // [R9]
	assign ps_pos.hgt    = f64(rx_sh_r, `MAPC_PV_OFS_HGT);   // [R9]
	assign ps_pos.lat_sd = f32(rx_sh_r, `MAPC_P_OFS_SLAT);   // [R9]
	assign ps_pos.lon_sd = f32(rx_sh_r, `MAPC_P_OFS_SLON);   // [R9]
	assign ps_pos.hgt_sd = f32(rx_sh_r, `MAPC_P_OFS_SHGT);   // [R9]

	// Velocity packet fields
	mapc_vel_s vs_vel;
	assign vs_vel.vn     = f32(rx_sh_r, `MAPC_V_OFS_VN);     // [R11]
	assign vs_vel.ve     = f32(rx_sh_r, `MAPC_V_OFS_VE);     // [R11]
	assign vs_vel.vd     = f32(rx_sh_r, `MAPC_V_OFS_VD);     // [R11]
	assign vs_vel.vn_sd  = f32(rx_sh_r, `MAPC_V_OFS_SVN);    // [R11]
	assign vs_vel.ve_sd  = f32(rx_sh_r, `MAPC_V_OFS_SVE);    // [R11]
	assign vs_vel.vd_sd  = f32(rx_sh_r, `MAPC_V_OFS_SVD);    // [R11]

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_pos_r     <= '0;
			rx_vel_r     <= '0;
			rx_pos_upd_r <= 1'b0;
			rx_vel_upd_r <= 1'b0;
			rx_err_r     <= 1'b0;
		end else begin
			rx_pos_upd_r <= is_pv || is_ps;  // [R5] [R8]
			rx_vel_upd_r <= is_pv || is_vs;  // [R5] [R10]
			rx_err_r     <= rx_fin && !rx_good;  // [R12]
			if (is_pv || is_ps) begin
				rx_pos_r <= is_pv ? pv_pos : ps_pos;
			end
			if (is_pv || is_vs) begin
				rx_vel_r <= is_pv ? pv_vel : vs_vel;
			end
		end
	end

	// ----------------------------------------------------------
	// Receive outputs
	// ----------------------------------------------------------

	assign rx_pos     = rx_pos_r;
	assign rx_vel     = rx_vel_r;
	assign rx_pos_upd = rx_pos_upd_r;
	assign rx_vel_upd = rx_vel_upd_r;
	assign rx_len_err = rx_err_r;
endmodule : mapc_codec

// >>> design/mapc_defs.svh
// Packet identifiers, lengths, field offsets and widths of the codec
`ifndef MAPC_DEFS_SVH
`define MAPC_DEFS_SVH
`define MAPC_ID_ANG_VEL     8'h2a
`define MAPC_ID_ANG_ACC     8'h2b
`define MAPC_ID_POS_VEL     8'h2c
`define MAPC_ID_POS         8'h2d
`define MAPC_ID_VEL         8'h2e
`define MAPC_LEN_ANG        8'h0c
`define MAPC_LEN_POS_VEL    8'h3c
`define MAPC_LEN_POS        8'h24
`define MAPC_LEN_VEL        8'h18
`define MAPC_OFS_X          8'h00
`define MAPC_OFS_Y          8'h04
`define MAPC_OFS_Z          8'h08
`define MAPC_PV_OFS_LAT     8'h00
`define MAPC_PV_OFS_LON     8'h08
`define MAPC_PV_OFS_HGT     8'h10
`define MAPC_PV_OFS_VN      8'h18
`define MAPC_PV_OFS_VE      8'h1c
`define MAPC_PV_OFS_VD      8'h20
`define MAPC_PV_OFS_SLAT    8'h24
`define MAPC_PV_OFS_SLON    8'h28
`define MAPC_PV_OFS_SHGT    8'h2c
`define MAPC_PV_OFS_SVN     8'h30
`define MAPC_PV_OFS_SVE     8'h34
`define MAPC_PV_OFS_SVD     8'h38
`define MAPC_P_OFS_SLAT     8'h18
`define MAPC_P_OFS_SLON     8'h1c
`define MAPC_P_OFS_SHGT     8'h20
`define MAPC_V_OFS_VN       8'h00
`define MAPC_V_OFS_VE       8'h04
`define MAPC_V_OFS_VD       8'h08
`define MAPC_V_OFS_SVN      8'h0c
`define MAPC_V_OFS_SVE      8'h10
`define MAPC_V_OFS_SVD      8'h14
`define MAPC_FP32_BYTES     8'h04
`define MAPC_FP64_BYTES     8'h08
`endif

// >>> design/mapc_field_sel.sv
// Little-endian byte selector into a field at an offset
module mapc_field_sel #(
	parameter int W = 8
) (
	input  wire logic [7:0]     base,
	input  wire logic [7:0]     idx,
	input  wire logic [W*8-1:0] field,
	output logic                hit,
	output logic [7:0]          lane
);
	logic [7:0] rel;
	assign rel  = idx - base;
	assign hit  = (idx >= base) && (rel < 8'(W));
	assign lane = hit ? field[rel[5:0]*8 +: 8] : 8'h00;
endmodule : mapc_field_sel

// >>> design/mapc_pkg.sv
// Types shared by the motion and aiding packet codec
package mapc_pkg;
	typedef logic [31:0] mapc_fp32_t;
	typedef logic [63:0] mapc_fp64_t;

	typedef struct packed {
		mapc_fp32_t x;
		mapc_fp32_t y;
		mapc_fp32_t z;
	} mapc_vec3_s;

	typedef struct packed {
		mapc_fp64_t lat;
		mapc_fp64_t lon;
		mapc_fp64_t hgt;
		mapc_fp32_t lat_sd;
		mapc_fp32_t lon_sd;
		mapc_fp32_t hgt_sd;
	} mapc_pos_s;

	typedef struct packed {
		mapc_fp32_t vn;
		mapc_fp32_t ve;
		mapc_fp32_t vd;
		mapc_fp32_t vn_sd;
		mapc_fp32_t ve_sd;
		mapc_fp32_t vd_sd;
	} mapc_vel_s;

	typedef struct packed {
		logic [7:0] id;
		logic [7:0] len;
	} mapc_hdr_s;

	typedef enum logic {
		MAPC_TX_IDLE,
		MAPC_TX_SEND
	} mapc_tx_e;
endpackage : mapc_pkg

// >>> verif/mapc_codec_asserts.sv
// Port checker of the packet codec
module mapc_codec_asserts (
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic                tx_av_req,
	input wire logic                tx_aa_req,
	input wire mapc_pkg::mapc_vec3_s tx_av,
	input wire logic                tx_busy,
	input wire mapc_pkg::mapc_hdr_s tx_hdr,
	input wire logic                tx_valid,
	input wire logic [7:0]          tx_data,
	input wire logic                tx_last,
	input wire logic                tx_ready,
	input wire mapc_pkg::mapc_hdr_s rx_hdr,
	input wire logic                rx_end,
	input wire logic                rx_pos_upd,
	input wire logic                rx_vel_upd,
	input wire logic                rx_len_err
);
	timeunit 1ns;
	timeprecision 1ns;
	import mapc_pkg::*;
	logic [3:0] cnt_r;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cnt_r <= 4'h0;
		else if (!tx_busy)
			cnt_r <= 4'h0;
		else if (tx_valid && tx_ready)
			cnt_r <= cnt_r + 4'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_av_start: assert property (
		!tx_busy && tx_av_req |=> tx_valid && tx_hdr == 16'h2a0c)
		else $error("rate header wrong");
	a_aa_start: assert property (
		!tx_busy && !tx_av_req && tx_aa_req |=> tx_hdr == 16'h2b0c)
		else $error("accel header wrong");
	a_first_byte: assert property (
		!tx_busy && tx_av_req |=> tx_data == $past(tx_av.x[7:0]))
		else $error("first byte wrong");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("byte dropped");
	a_last_byte: assert property (
		tx_valid && tx_last |-> cnt_r == 4'hb)
		else $error("last byte misplaced");
	a_pos_len_err: assert property (
		rx_end && rx_hdr.id == 8'h2d && rx_hdr.len != 8'h24
		|=> rx_len_err && !rx_pos_upd)
		else $error("bad position length kept");
	a_vel_len_err: assert property (
		rx_end && rx_hdr.id == 8'h2e && rx_hdr.len != 8'h18
		|=> rx_len_err && !rx_vel_upd)
		else $error("bad velocity length kept");
	a_pv_both: assert property (
		rx_pos_upd && $past(rx_hdr.id) == 8'h2c |-> rx_vel_upd)
		else $error("combined packet half applied");
	a_foreign_id: assert property (
		rx_end && (rx_hdr.id < 8'h2c || rx_hdr.id > 8'h2e)
		|=> !rx_len_err && !rx_pos_upd && !rx_vel_upd)
		else $error("foreign packet acted on");
endmodule : mapc_codec_asserts

bind mapc_codec mapc_codec_asserts i_mapc_codec_asserts (
	.clk(clk), .arst_n(arst_n), .tx_av_req(tx_av_req),
	.tx_aa_req(tx_aa_req), .tx_av(tx_av), .tx_busy(tx_busy),
	.tx_hdr(tx_hdr), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_last(tx_last), .tx_ready(tx_ready), .rx_hdr(rx_hdr),
	.rx_end(rx_end), .rx_pos_upd(rx_pos_upd),
	.rx_vel_upd(rx_vel_upd), .rx_len_err(rx_len_err)
);

// >>> verif/mapc_host.sv
// Host and aiding source model facing the codec
module mapc_host (
	input  wire logic           clk,
	input  wire logic           slow,
	output mapc_pkg::mapc_hdr_s rx_hdr,
	output logic                rx_start,
	output logic                rx_valid,
	output logic [7:0]          rx_data,
	output logic                rx_end,
	output logic                tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	import mapc_pkg::*;
	integer seed_r = 7;
	initial begin
		rx_hdr = 16'h0;
		rx_start = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h0;
		rx_end = 1'b0;
	end
	// Byte sink, stalls at random when slow
	always @(posedge clk)
		tx_ready <= !slow || $random(seed_r) % 2 == 0;
	// Frames a payload, byte 0 first, LSB of each field first
	task automatic send(input logic [15:0] hdr, input logic [479:0] pl,
		input int n);
		@(posedge clk);
		rx_hdr <= hdr;
		rx_start <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rx_start <= 1'b0;
			rx_valid <= 1'b1;
			rx_data <= pl[8*i+:8];
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
	endtask : send
endmodule : mapc_host

// >>> verif/test_mapc_codec.sv
// Self-checking bench of the packet codec
module test_mapc_codec;
	timeunit 1ns;
	timeprecision 1ns;
	import mapc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic tx_av_req = 1'b0;
	logic tx_aa_req = 1'b0;
	logic slow = 1'b0;
	mapc_vec3_s tx_av = '0;
	mapc_vec3_s tx_aa = '0;
	logic tx_busy, tx_valid, tx_last, tx_ready, rx_start, rx_valid, rx_end;
	logic rx_pos_upd, rx_vel_upd, rx_len_err;
	logic [7:0] tx_data, rx_data;
	mapc_hdr_s tx_hdr, rx_hdr;
	mapc_pos_s rx_pos, p, qpos[$];
	mapc_vel_s rx_vel, v, qvel[$];
	logic [24:0] qtx[$];
	int qerr, fail_count, n_tests, k;
	integer seed = 32'hfe29;
	always #20 clk = ~clk;
	mapc_codec i_mapc_codec (.clk(clk), .arst_n(arst_n),
		.tx_av_req(tx_av_req), .tx_aa_req(tx_aa_req), .tx_av(tx_av),
		.tx_aa(tx_aa), .tx_busy(tx_busy), .tx_hdr(tx_hdr),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .rx_hdr(rx_hdr), .rx_start(rx_start),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
		.rx_pos(rx_pos), .rx_vel(rx_vel), .rx_pos_upd(rx_pos_upd),
		.rx_vel_upd(rx_vel_upd), .rx_len_err(rx_len_err));
	mapc_host i_mapc_host (.clk(clk), .slow(slow), .rx_hdr(rx_hdr),
		.rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_end(rx_end), .tx_ready(tx_ready));
	task automatic results();
		$display("Checks %0d, errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic check(input logic [319:0] seen, input logic [319:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [319:0] rnd();
		for (int i = 0; i < 10; i++)
			rnd[32*i+:32] = $random(seed);
	endfunction : rnd
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			check(320'({tx_hdr, tx_last, tx_data}), 320'(qtx.pop_front()));
		if (rx_pos_upd)
			check(320'(rx_pos), 320'(qpos.pop_front()));
		if (rx_vel_upd)
			check(320'(rx_vel), 320'(qvel.pop_front()));
		if (rx_len_err) begin
			check(320'(qerr > 0), 320'(1));
			qerr--;
		end
	end
	task automatic tx(input logic av, input logic both, input mapc_vec3_s d);
		logic [95:0] b;
		int j;
		b = {d.z, d.y, d.x};
		for (int i = 0; i < 12; i++)
			qtx.push_back({av ? 16'h2a0c : 16'h2b0c, i == 11, b[8*i+:8]});
		tx_av <= av ? d : ~d;
		tx_aa <= av ? ~d : d;
		tx_av_req <= av || both;
		tx_aa_req <= !av || both;
		@(posedge clk);
		tx_av_req <= 1'b0;
		tx_aa_req <= 1'b1;
		@(posedge clk);
		tx_aa_req <= 1'b0;
		check(320'(tx_busy), 320'(1));
		for (j = 0; j < 300 && tx_busy !== 1'b0; j++)
			@(posedge clk);
		if (j == 300) begin
			fail_count++;
			results();
		end
	endtask : tx
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 4; k++) begin
			p = rnd();
			slow <= k[0];
			tx(k != 1, k == 3, p[95:0]);
		end
		p = rnd();
		v = p[191:0];
		p = rnd();
		qvel.push_back(v);
		i_mapc_host.send(16'h2e18, 480'({v.vd_sd, v.ve_sd, v.vn_sd,
			v.vd, v.ve, v.vn}), 24);
		qpos.push_back(p);
		i_mapc_host.send(16'h2d24, 480'({p.hgt_sd, p.lon_sd, p.lat_sd,
			p.hgt, p.lon, p.lat}), 36);
		qpos.push_back(p);
		qvel.push_back(v);
		i_mapc_host.send(16'h2c3c, 480'({v.vd_sd, v.ve_sd, v.vn_sd,
			p.hgt_sd, p.lon_sd, p.lat_sd, v.vd, v.ve, v.vn, p.hgt,
			p.lon, p.lat}), 60);
		qerr = 3;
		i_mapc_host.send(16'h2d20, 480'(p), 32);
		i_mapc_host.send(16'h2e10, 480'(v), 16);
		i_mapc_host.send(16'h2c3c, 480'(p), 59);
		i_mapc_host.send(16'h2f18, 480'(v), 24);
		repeat (4) @(posedge clk);
		check(320'(qerr + qpos.size() + qvel.size()), 320'(0));
		results();
	end
endmodule : test_mapc_codec
